// ===== logic/tsi_switch.sv
// Notes on behaviour
// R1: Four paths switch together, each non-blocking to 4,096 channels.
// R2: Unidirectional use treats all 32 inputs and outputs as one switch.
// R3: Unequal blocking splits between sides come from programming alone.
// R4: Local port has sixteen inputs and outputs, each at one of four rates.
// R5: Backplane port: sixteen inputs and outputs, each at one of four rates.
// R6: Each local input stream takes its rate from its own register.
// R7: Each local output stream takes its rate from its own register.
// R8: Each backplane input stream takes its rate from its own register.
// R9: Each backplane output stream takes its rate from its own register.
// R10: Local connection entry source bit picks backplane or local data memory.
// R11: Backplane entry source bit picks backplane or local data memory.
// R12: Local entry message bit sends entry contents instead of switched data.
// R13: Backplane entry message bit sends entry contents, not switched data.
// R14: Local entry drive bit drives the channel or leaves it high-impedance.
// R15: Backplane entry drive bit drives or floats its backplane channel.
// R16: Streams carry 256, 128, 64 or 32 channels per frame by rate.
// R17: Inputs are stored once per frame; outputs read where their entry points.
// R18: Host programs rates and entries consistently, naming real channels.
`default_nettype none
module tsi_switch
  import tsi_pkg::*;
#(
  parameter int BIT_DIVIDE = BIT_DIV
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] local_serial_in_i,
  input wire logic [15:0] backplane_serial_in_i,
  output logic [15:0] local_serial_out_o,
  output logic [15:0] local_serial_out_oe_n_o,
  output logic [15:0] backplane_serial_out_o,
  output logic [15:0] backplane_serial_out_oe_n_o,
  output logic frame_start_o
);
  typedef struct packed {
    logic [7:0] div;
    logic [10:0] bitcnt;
    logic [15:0] frames;
    logic fstart;
    rate_e [3:0][15:0] rate;
    logic out_en;
    logic [12:0] cm_addr;
    logic [31:0] prdata;
    logic slverr;
    logic [31:0] sy1, sy2, pend, need, drv_en, ondrv, odrv, sout;
    logic [31:0][7:0] ish, ibyte, ich, ocur, onext, fch;
    logic [4:0] scan;
  } switch_s;

  switch_s st_reg;
  switch_s st_next;

  logic [7:0] dm_mem [0:MEM_WORDS-1];
  logic [14:0] cm_mem [0:MEM_WORDS-1];

  logic tick;
  logic [10:0] nc;
  logic go;
  logic push;
  logic setup;
  logic access;
  logic hit;
  logic cm_we;
  logic [31:0] rd_val;
  cm_entry_s entry;
  logic [14:0] cm_rd;
  logic [7:0] dm_rd;
  dm_write_s f_in;
  dm_write_s f_out;
  logic f_in_ready;
  logic f_out_valid;
  logic [4:0] f_level;
  rate_e ri;
  rate_e ro;
  logic [10:0] pin;
  logic [10:0] pout;

  function automatic logic at_edge(input logic [10:0] c, input rate_e r);
    logic [10:0] m;
    m = (11'h001 << (2'h3 - 2'(r))) - 11'h001;
    return (c & m) == 11'h000;
  endfunction

  function automatic logic [10:0] spos(input logic [10:0] c, input rate_e r);
    return c >> (2'h3 - 2'(r));
  endfunction

  function automatic logic [7:0] chan_mask(input rate_e r);
    return 8'((9'h020 << 2'(r)) - 9'h001);
  endfunction

  assign tick = st_reg.div == 8'(BIT_DIVIDE - 1);
  assign nc = st_reg.bitcnt + 11'h001;
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign cm_we = access && pwrite_i && paddr_i == OFF_CM_DATA;

  // Any output reaches any of the 32 input streams on either side.
  assign entry = cm_mem[{st_reg.scan, st_reg.fch[st_reg.scan]}]; // see R2
  assign dm_rd =
    dm_mem[{entry.source_sel, entry.stream, entry.chan}]; // see R3 R11
  assign cm_rd = cm_mem[st_reg.cm_addr];
  assign go = st_reg.need[st_reg.scan];
  assign push = st_reg.pend[st_reg.scan] && f_in_ready;
  assign f_in.addr = {st_reg.scan, st_reg.ich[st_reg.scan]};
  assign f_in.data = st_reg.ibyte[st_reg.scan];

  assign hit = paddr_i[1:0] == 2'h0 && (paddr_i < OFF_CTRL ||
    paddr_i == OFF_CTRL || paddr_i == OFF_CM_ADDR ||
    paddr_i == OFF_CM_DATA || paddr_i == OFF_STATUS);

  // Captured bytes queue here so that many streams can finish together.
  stream_fifo #(
    .WIDTH($bits(dm_write_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(st_reg.pend[st_reg.scan]),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in),
    .out_valid_o(f_out_valid),
    .out_ready_i(!go),
    .out_data_o(f_out),
    .level_o(f_level)
  );

  always_comb begin
    rd_val = 32'h0000_0000;
    if (paddr_i < OFF_CTRL) begin
      rd_val = {30'h0000_0000, st_reg.rate[paddr_i[7:6]][paddr_i[5:2]]};
    end else begin
      case (paddr_i)
        OFF_CTRL: rd_val = {31'h0000_0000, st_reg.out_en};
        OFF_CM_ADDR: rd_val = {19'h0_0000, st_reg.cm_addr};
        OFF_CM_DATA: rd_val = {17'h0_0000, cm_rd};
        OFF_STATUS: rd_val = {11'h000, f_level, st_reg.frames};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    st_next = st_reg;
    ri = RATE_2M;
    ro = RATE_2M;
    pin = 11'h000;
    pout = 11'h000;
    st_next.sy1 = {backplane_serial_in_i, local_serial_in_i};
    st_next.sy2 = st_reg.sy1;
    st_next.div = tick ? 8'h00 : st_reg.div + 8'h01;
    st_next.fstart = tick && nc == 11'h000;
    if (tick) begin
      st_next.bitcnt = nc;
    end
    if (st_next.fstart) begin
      st_next.frames = st_reg.frames + 16'h0001;
    end
    st_next.scan = st_reg.scan + 5'h01;
    if (push) begin
      st_next.pend[st_reg.scan] = 1'b0;
    end
    // Message entries send their own byte, others the addressed data.
    if (go) begin
      st_next.onext[st_reg.scan] =
        entry.msg_mode_bit ? entry.chan : dm_rd; // see R12 R13
      st_next.ondrv[st_reg.scan] = entry.chan_hiz_ctl; // see R14
      st_next.need[st_reg.scan] = 1'b0;
    end
    for (int s = 0; s < NUM_ALL; s++) begin
      ri = st_reg.rate[2 * (s / NUM_STREAMS)][s % NUM_STREAMS]; // see R6
      ro = st_reg.rate[2 * (s / NUM_STREAMS) + 1][s % NUM_STREAMS]; // see R7
      // Sample each input at the end of its own bit period.
      if (tick && at_edge(nc, ri)) begin // see R8
        pin = spos(st_reg.bitcnt, ri);
        st_next.ish[s] = {st_reg.ish[s][6:0], st_reg.sy2[s]};
        if (pin[2:0] == 3'h7) begin
          st_next.ibyte[s] = {st_reg.ish[s][6:0], st_reg.sy2[s]}; // see R17
          st_next.ich[s] = pin[10:3]; // see R16
          st_next.pend[s] = 1'b1;
        end
      end
      // Shift each output at its own rate; a new channel asks for a fetch.
      if (tick && at_edge(nc, ro)) begin // see R9
        pout = spos(nc, ro);
        if (pout[2:0] == 3'h0) begin
          st_next.ocur[s] = st_reg.onext[s];
          st_next.odrv[s] = st_reg.ondrv[s];
          st_next.need[s] = 1'b1;
          st_next.fch[s] = (pout[10:3] + 8'h01) & chan_mask(ro);
          st_next.sout[s] = st_reg.onext[s][7];
        end else begin
          st_next.sout[s] = st_reg.ocur[s][3'h7 - pout[2:0]]; // see R4
        end
      end
      st_next.drv_en[s] = st_reg.out_en && st_next.odrv[s]; // see R15
    end
    if (setup) begin
      st_next.slverr = !hit;
      st_next.prdata = (hit && !pwrite_i) ? rd_val : 32'h0000_0000;
    end
    if (access && pwrite_i && hit) begin
      if (paddr_i < OFF_CTRL) begin
        st_next.rate[paddr_i[7:6]][paddr_i[5:2]] =
          rate_e'(pwdata_i[1:0]); // see R5
      end else begin
        case (paddr_i)
          OFF_CTRL: st_next.out_en = pwdata_i[CTRL_OUT_EN_BIT];
          OFF_CM_ADDR: st_next.cm_addr = pwdata_i[12:0];
          OFF_CM_DATA: st_next.cm_addr = st_reg.cm_addr + 13'h0001;
          default: st_next.cm_addr = st_reg.cm_addr;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Local and backplane entries share one store, indexed by output side.
  always_ff @(posedge clk_i) begin
    if (cm_we) begin
      cm_mem[st_reg.cm_addr] <= pwdata_i[14:0]; // see R10
    end
  end

  // Both data memories drain from the queue between fetches.
  always_ff @(posedge clk_i) begin
    if (f_out_valid && !go) begin
      dm_mem[f_out.addr] <= f_out.data; // see R1
    end
  end

  assign pready_o = 1'b1;
  assign prdata_o = st_reg.prdata;
  assign pslverr_o = st_reg.slverr && access;
  assign local_serial_out_o = st_reg.sout[15:0];
  assign local_serial_out_oe_n_o = ~st_reg.drv_en[15:0];
  assign backplane_serial_out_o = st_reg.sout[31:16];
  assign backplane_serial_out_oe_n_o = ~st_reg.drv_en[31:16];
  assign frame_start_o = st_reg.fstart;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_lin_rate_write: assert property ( // see R6
    access && pwrite_i && paddr_i[11:6] == 6'h00 && paddr_i[1:0] == 2'h0
    |=> st_reg.rate[GRP_LIN][$past(paddr_i[5:2])] ==
        rate_e'($past(pwdata_i[1:0])))
    else $error("Local input rate register did not take the write.");

  a_bout_rate_write: assert property ( // see R9
    access && pwrite_i && paddr_i[11:6] == 6'h03 && paddr_i[1:0] == 2'h0
    |=> st_reg.rate[GRP_BOUT][$past(paddr_i[5:2])] ==
        rate_e'($past(pwdata_i[1:0])))
    else $error("Backplane output rate register did not take the write.");

  a_local_msg_byte: assert property ( // see R12
    go && st_reg.scan == 5'h00 && entry.msg_mode_bit
    |=> st_reg.onext[0] == $past(entry.chan))
    else $error("Local message channel did not carry the entry byte.");

  a_bp_msg_byte: assert property ( // see R13
    go && st_reg.scan == 5'h10 && entry.msg_mode_bit
    |=> st_reg.onext[16] == $past(entry.chan))
    else $error("Backplane message channel did not carry the entry byte.");

  a_local_src_data: assert property ( // see R10
    go && !st_reg.scan[4] && !entry.msg_mode_bit
    |=> st_reg.onext[$past(st_reg.scan)] == $past(dm_rd) &&
        st_reg.ondrv[$past(st_reg.scan)] == $past(entry.chan_hiz_ctl))
    else $error("Local output did not take the selected data memory byte.");

  a_bp_src_data: assert property ( // see R11
    go && st_reg.scan[4] && !entry.msg_mode_bit
    |=> st_reg.onext[$past(st_reg.scan)] == $past(dm_rd))
    else $error("Backplane output did not take the selected data byte.");

  a_local_hiz_drive: assert property ( // see R14
    st_reg.drv_en[0] |-> $past(st_reg.out_en) && st_reg.odrv[0])
    else $error("Local channel driven without its drive bit.");

  a_bp_hiz_drive: assert property ( // see R15
    st_reg.drv_en[16] |-> $past(st_reg.out_en) && st_reg.odrv[16])
    else $error("Backplane channel driven without its drive bit.");

  a_chan_in_range: assert property ( // see R16
    st_reg.need[0] |->
    (st_reg.fch[0] & ~chan_mask(st_reg.rate[GRP_LOUT][0])) == 8'h00)
    else $error("Fetched channel exceeds the channels of the stream rate.");

  a_fetch_bound: assert property ( // see R17
    $rose(st_reg.need[5]) |-> ##[1:32] !st_reg.need[5])
    else $error("Output fetch not served within one scan.");

  a_push_hold: assert property ( // see R17
    st_reg.pend[st_reg.scan] && !f_in_ready
    |=> st_reg.pend[$past(st_reg.scan)])
    else $error("Captured byte lost while the queue was full.");

  a_frame_count: assert property ( // see R1
    tick && st_reg.bitcnt == 11'h7FF
    |=> st_reg.fstart && st_reg.frames == $past(st_reg.frames) + 16'h0001)
    else $error("Frame boundary not marked or not counted.");

  c_msg_fetch: cover property (go && entry.msg_mode_bit);
  c_data_fetch: cover property (go && !entry.msg_mode_bit && entry.source_sel);
  c_fifo_full: cover property (!f_in_ready);
  c_bus_error: cover property (access && pslverr_o);
endmodule
`default_nettype wire

// ===== shared/tsi_pkg.sv
`default_nettype none
package tsi_pkg;
  localparam int NUM_STREAMS = 16;
  localparam int NUM_ALL = 32;
  localparam int MEM_WORDS = 8192;
  localparam int FIFO_DEPTH = 16;
  localparam int FRAME_BITS = 2048;

  // Bit period of the fastest stream rate and the clock period.
  localparam real CLK_NS = 4.0;
  localparam real BIT16_NS = 61.035;
  localparam int BIT_DIV = int'($floor(BIT16_NS / CLK_NS));

  localparam logic [11:0] OFF_LOCAL_IN_RATE_REG = 12'h000;
  localparam logic [11:0] OFF_LOCAL_OUT_RATE_REG = 12'h040;
  localparam logic [11:0] OFF_BACKPLANE_IN_RATE_REG = 12'h080;
  localparam logic [11:0] OFF_BACKPLANE_OUT_RATE_REG = 12'h0C0;
  localparam logic [11:0] OFF_CTRL = 12'h100;
  localparam logic [11:0] OFF_CM_ADDR = 12'h104;
  localparam logic [11:0] OFF_CM_DATA = 12'h108;
  localparam logic [11:0] OFF_STATUS = 12'h10C;

  localparam int GRP_LIN = 0;
  localparam int GRP_LOUT = 1;
  localparam int GRP_BIN = 2;
  localparam int GRP_BOUT = 3;
  localparam int CTRL_OUT_EN_BIT = 0;

  // Stream rates; the reset value of every rate register is the first.
  typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M} rate_e;
  localparam rate_e RATE_RESET = RATE_2M;
  localparam logic CTRL_RESET = 1'b0;

  // One connection memory entry; chan_hiz_ctl high drives the channel.
  typedef struct packed {
    logic source_sel;
    logic msg_mode_bit;
    logic chan_hiz_ctl;
    logic [3:0] stream;
    logic [7:0] chan;
  } cm_entry_s;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] data;
  } dm_write_s;
endpackage
`default_nettype wire

// ===== logic/stream_fifo.sv
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s st_reg;
  fifo_s st_next;
  logic push;
  logic pop;

  assign in_ready_o = st_reg.cnt != (AW + 1)'(DEPTH);
  assign out_valid_o = st_reg.cnt != '0;
  assign out_data_o = st_reg.mem[st_reg.rd];
  assign level_o = st_reg.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data_i;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ===== bench/tdm_far_end.sv
`default_nettype none
module tdm_far_end (
  input wire logic clk_i,
  input wire logic reset_n_i,
  output logic [15:0] local_serial_in_o,
  output logic [15:0] backplane_serial_in_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Local streams carry all ones and backplane streams all zeros.
  // While in reset the lines change every cycle, as nothing is framed yet.
  initial begin
    local_serial_in_o = 16'hAAAA;
    backplane_serial_in_o = 16'h5555;
    forever begin
      @(posedge clk_i);
      if (!reset_n_i) begin
        local_serial_in_o <= ~local_serial_in_o;
        backplane_serial_in_o <= ~backplane_serial_in_o;
      end else begin
        local_serial_in_o <= 16'hFFFF;
        backplane_serial_in_o <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tsi_switch_tb.sv
`default_nettype none
module tsi_switch_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsi_pkg::*;
  localparam int BD = 5;
  logic clk_i, reset_n_i, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, frame_start;
  logic [15:0] lin, bin, lout, loe_n, bout, boe_n;
  logic [15:0] cfg [8];
  logic [7:0] exp_out, exp_oe_n;
  int err_count, tests_run, cycles, n;

  tsi_switch #(.BIT_DIVIDE(BD)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .local_serial_in_i(lin),
    .backplane_serial_in_i(bin), .local_serial_out_o(lout),
    .local_serial_out_oe_n_o(loe_n), .backplane_serial_out_o(bout),
    .backplane_serial_out_oe_n_o(boe_n), .frame_start_o(frame_start));
  tdm_far_end u_far (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .local_serial_in_o(lin), .backplane_serial_in_o(bin));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_frame();
    do @(posedge clk_i); while (frame_start !== 1'b1);
  endtask

  // Fills all 32 channels of one output stream with one entry pattern.
  task automatic program_stream(input int i);
    logic [15:0] c;
    c = cfg[i];
    apb(1'b1, OFF_CM_ADDR, {19'h0, c[15], 4'(i % 4), 8'h00});
    for (int ch = 0; ch < 32; ch++) begin
      apb(1'b1, OFF_CM_DATA, {17'h0, c[14:8], c[13] ? c[7:0] : 8'(ch)});
    end
  endtask

  initial begin
    cfg = '{16'h30FF, 16'h20FF, 16'h5200, 16'h1200,
            16'hB000, 16'h9200, 16'hD200, 16'hA000};
    exp_out = 8'h29;
    exp_oe_n = 8'h82;
    err_count = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    check("oe_n after reset", {loe_n, boe_n}, 32'hFFFFFFFF);
    // Every rate register starts at the slowest rate.
    for (int a = 0; a < 64; a++) begin
      apb(1'b0, 12'(4 * a), 32'h0);
      check("rate reset", rd, 32'h0);
    end
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    // Each group, streams 12 to 15, takes all four rate codes.
    for (int g = 0; g < 4; g++) begin
      for (int s = 12; s < 16; s++) begin
        n = (s + g) % 4;
        apb(1'b1, 12'(64 * g + 4 * s), 32'hFFFFFFFC | 32'(n));
        apb(1'b0, 12'(64 * g + 4 * s), 32'h0);
        check("rate code", rd, 32'(n));
      end
    end
    apb(1'b0, 12'h200, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h001, 32'h3);
    check("misaligned err", {31'h0, err}, 32'h1);
    apb(1'b0, OFF_LOCAL_IN_RATE_REG, 32'h0);
    check("misaligned ignored", rd, 32'h0);
    // Let one whole frame fill the data memories before fetching.
    wait_frame();
    for (int i = 0; i < 8; i++) begin
      program_stream(i);
    end
    apb(1'b0, OFF_CM_ADDR, 32'h0);
    check("cm addr advance", rd, 32'h1320);
    apb(1'b1, OFF_CM_ADDR, 32'h0305);
    apb(1'b0, OFF_CM_DATA, 32'h0);
    check("cm entry", rd, 32'h1205);
    apb(1'b1, OFF_CTRL, 32'h1);
    wait_frame();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (frame_start !== 1'b1 && n < 20000);
    check("frame length", 32'(n), 32'(2048 * BD));
    repeat (2) wait_frame();
    repeat (4000) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      if (i < 4) begin
        check("local oe_n", 32'(loe_n[i]), 32'(exp_oe_n[i]));
        if (!exp_oe_n[i]) begin
          check("lout", 32'(lout[i]), 32'(exp_out[i]));
        end
      end else begin
        check("bp oe_n", 32'(boe_n[i - 4]), 32'(exp_oe_n[i]));
        if (!exp_oe_n[i]) begin
          check("bout", 32'(bout[i - 4]), 32'(exp_out[i]));
        end
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
